// ==== src/ebps_defines.vh ====
// Purpose: Register offsets, field positions, reset values and timing counts
//          of the external bus phase sequencer.
// Assumes: 250 MHz APB clock; 32-bit APB data, one register per aligned word.
// Notes:   Definitions only; included by bare name.
`ifndef EBPS_DEFINES_VH
`define EBPS_DEFINES_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define EBPS_OFS_CTRL 8'h00
`define EBPS_OFS_TIMING 8'h04
`define EBPS_OFS_DIV 8'h08
`define EBPS_OFS_CMD 8'h0c
`define EBPS_OFS_ADDR 8'h10
`define EBPS_OFS_WDATA 8'h14
`define EBPS_OFS_RDATA 8'h18
`define EBPS_OFS_STATUS 8'h1c

// ****************************************************************
// Control register fields
// ****************************************************************
`define EBPS_CTRL_RDY_EN 0
`define EBPS_CTRL_RDY_POL 1
`define EBPS_CTRL_RDY_ASYNC 2
`define EBPS_CTRL_REFERENCE_BUS_CLOCK_OUTPUT_EN 3
`define EBPS_CTRL_W 4
`define EBPS_CTRL_RST 4'h0

// ****************************************************************
// Chip select timing configuration fields
// ****************************************************************
`define EBPS_T_AB 0
`define EBPS_T_ABX_LSB 1
`define EBPS_T_CMD_LSB 3
`define EBPS_T_WSU 5
`define EBPS_T_ACC_LSB 6
`define EBPS_T_HOLD_LSB 11
`define EBPS_T_W 13
`define EBPS_TIMING_RST 13'h0000
`define EBPS_DIV_RST 8'h00

// ****************************************************************
// Status fields and bus geometry
// ****************************************************************
`define EBPS_ST_BUSY 0
`define EBPS_ST_DONE 1
`define EBPS_ST_PH_LSB 2
`define EBPS_WIN_LSB 20
`define EBPS_WIN_W 4

// ****************************************************************
// Timing: least distance between bus signal transitions
// ****************************************************************
`define EBPS_CLK_PERIOD_PS 4000
`define EBPS_MIN_GAP_PS 12500
`define EBPS_MIN_STEP_CYC ((`EBPS_MIN_GAP_PS + `EBPS_CLK_PERIOD_PS - 1) / `EBPS_CLK_PERIOD_PS)

`endif

// ==== src/ebps_sync.v ====
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs asynchronous to clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module ebps_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // ebps_sync

`default_nettype wire

// ==== src/ebps_step_div.v ====
// Purpose: Divider producing the one-cycle timing step enable.
// Assumes: One clock; clr restarts the step grid.
// Notes:   A step never gets shorter than MIN_CYC clocks.
`timescale 1ns/1ps
`default_nettype none

module ebps_step_div #(
	parameter MIN_CYC = 4
) (
	input wire clk,
	input wire rst_n,
	input wire clr,
	input wire [7:0] div,
	output reg step
);

	localparam integer MIN_LOAD_I = MIN_CYC - 1;
	localparam [7:0] MIN_LOAD = MIN_LOAD_I[7:0];

	reg [7:0] cnt_q;
	wire [7:0] load = (div < MIN_LOAD) ? MIN_LOAD : div;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			step <= 1'b0;
		end else if (clr) begin
			cnt_q <= load;
			step <= 1'b0;
		end else if (cnt_q == 8'h00) begin
			cnt_q <= load;
			step <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 8'h01;
			step <= 1'b0;
		end
	end

endmodule // ebps_step_div

`default_nettype wire

// ==== src/ebps_top.v ====
// Purpose: Sequencer for cycles on the external parallel bus, programmed over APB.
// Assumes: pclk at 250 MHz; bus pins sampled through two flip-flops.
// Notes:   Zero-wait APB slave; one bus cycle at a time.
`timescale 1ns/1ps
`default_nettype none
`include "ebps_defines.vh"

// Contract
// - Five phases in fixed order per cycle
// - Phase lengths come from timing configuration
// - Optional ready handshake stretches access phase
// - Setup one-two steps, plus zero-three on window change
// - Command 0-3, write setup 0-1, access 1-32
// - Hold phase zero to three steps
// - Bus transitions within a cycle at least 12.5 ns apart; select can rise and fall again one pclk apart between cycles
// - System clock routed out with fast driver
// - Ready polarity selectable by software
// - Asynchronous ready gets extra synchroniser stage
// - Ready inactive waits, active ends access phase
// - Read data captured when read strobe rises
module ebps_top #(
	parameter ADDR_W = 24,
	parameter DATA_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg [ADDR_W-1:0] bus_addr,
	output reg [DATA_W-1:0] bus_wdata,
	output reg bus_data_oe_n,
	input wire [DATA_W-1:0] bus_rdata_in,
	output reg bus_cs_n,
	output reg bus_rd_n,
	output reg bus_wr_n,
	input wire bus_ready_in,
	output wire external_clock_output_pin,
	output reg ext_clk_hs_drv_en
);

	// ****************************************************************
	// Phase states
	// ****************************************************************
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_AB = 6'h02;
	localparam [5:0] ST_C = 6'h04;
	localparam [5:0] ST_D = 6'h08;
	localparam [5:0] ST_E = 6'h10;
	localparam [5:0] ST_F = 6'h20;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function addr_hit;
		input [7:0] a;
		begin
			case (a)
				`EBPS_OFS_CTRL, `EBPS_OFS_TIMING, `EBPS_OFS_DIV, `EBPS_OFS_CMD,
				`EBPS_OFS_ADDR, `EBPS_OFS_WDATA, `EBPS_OFS_RDATA,
				`EBPS_OFS_STATUS: addr_hit = 1'b1;
				default: addr_hit = 1'b0;
			endcase
		end
	endfunction

	// Next phase after ph; phases of zero length are passed over
	function [5:0] next_phase;
		input [5:0] ph;
		input [`EBPS_T_W-1:0] t;
		begin
			case (ph)
				ST_AB: begin
					if (t[`EBPS_T_CMD_LSB +: 2] != 2'h0)
						next_phase = ST_C;
					else if (t[`EBPS_T_WSU])
						next_phase = ST_D;
					else
						next_phase = ST_E;
				end
				ST_C: next_phase = t[`EBPS_T_WSU] ? ST_D : ST_E;
				ST_D: next_phase = ST_E;
				ST_E: next_phase = (t[`EBPS_T_HOLD_LSB +: 2] != 2'h0) ? ST_F : ST_IDLE;
				default: next_phase = ST_IDLE;
			endcase
		end
	endfunction

	// Length in timing steps of phases C to F
	function [5:0] phase_len;
		input [5:0] ph;
		input [`EBPS_T_W-1:0] t;
		begin
			case (ph)
				ST_C: phase_len = {4'h0, t[`EBPS_T_CMD_LSB +: 2]};
				ST_D: phase_len = {5'h00, t[`EBPS_T_WSU]};
				ST_E: phase_len = {1'b0, t[`EBPS_T_ACC_LSB +: 5]} + 6'h01;
				ST_F: phase_len = {4'h0, t[`EBPS_T_HOLD_LSB +: 2]};
				default: phase_len = 6'h00;
			endcase
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg [`EBPS_CTRL_W-1:0] ctrl_q;
	reg [`EBPS_T_W-1:0] timing_q;
	reg [`EBPS_T_W-1:0] cur_t_q;
	reg [7:0] div_q;
	reg rw_q;
	reg [ADDR_W-1:0] addr_q;
	reg [DATA_W-1:0] wdata_q;
	reg [DATA_W-1:0] rdata_q;
	reg done_q;
	reg [`EBPS_WIN_W-1:0] last_win_q;
	reg win_valid_q;
	reg [5:0] st_q;
	reg [5:0] st_d;
	reg [5:0] cnt_q;
	reg [5:0] cnt_d;
	reg cyc_end;
	reg capture;
	reg ready_x_q;
	reg [31:0] rd_mux;

	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable;
	wire hit = addr_hit(paddr);
	wire apb_wr = apb_acc & pwrite & hit;
	wire busy = (st_q != ST_IDLE);
	wire start = apb_wr & (paddr == `EBPS_OFS_CMD) & ~busy;
	wire done_clr = apb_wr & (paddr == `EBPS_OFS_STATUS) & pwdata[`EBPS_ST_DONE];
	wire [`EBPS_WIN_W-1:0] new_win = addr_q[`EBPS_WIN_LSB +: `EBPS_WIN_W];
	wire win_chg = ~win_valid_q | (new_win != last_win_q);
	wire step;

	// Setup phase: base one or two steps, window change adds up to three
	wire [5:0] ab_len = {5'h00, timing_q[`EBPS_T_AB]} + 6'h01 +
		(win_chg ? {4'h0, timing_q[`EBPS_T_ABX_LSB +: 2]} : 6'h00);

	assign pready = 1'b1;
	assign pslverr = apb_acc & ~hit;

	// ****************************************************************
	// Pin inputs and ready handshake
	// ****************************************************************
	wire [DATA_W:0] pins_s;
	wire ready_s = pins_s[DATA_W];
	wire [DATA_W-1:0] rdata_s = pins_s[DATA_W-1:0];

	ebps_sync #(
		.WIDTH(DATA_W + 1)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({bus_ready_in, bus_rdata_in}),
		.q(pins_s)
	);

	// Async ready takes one more stage; costs at most one waitstate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ready_x_q <= 1'b0;
		else
			ready_x_q <= ready_s;
	end

	wire ready_lvl = ctrl_q[`EBPS_CTRL_RDY_ASYNC] ? ready_x_q : ready_s;
	wire ready_act = (ready_lvl == ctrl_q[`EBPS_CTRL_RDY_POL]);

	// ****************************************************************
	// Timing step grid
	// ****************************************************************
	ebps_step_div #(
		.MIN_CYC(`EBPS_MIN_STEP_CYC)
	) u_step (
		.clk(pclk),
		.rst_n(presetn),
		.clr(start),
		.div(div_q),
		.step(step)
	);

	// ****************************************************************
	// Phase sequencer
	// ****************************************************************
	always @* begin
		st_d = st_q;
		cnt_d = cnt_q;
		cyc_end = 1'b0;
		capture = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d = ST_AB;
					cnt_d = ab_len;
				end
			end
			ST_AB, ST_C, ST_D, ST_E, ST_F: begin
				if (step) begin
					if (cnt_q > 6'h01) begin
						cnt_d = cnt_q - 6'h01;
					end else if ((st_q == ST_E) && ctrl_q[`EBPS_CTRL_RDY_EN] && !ready_act) begin
						cnt_d = cnt_q;
					end else begin
						st_d = next_phase(st_q, cur_t_q);
						cnt_d = phase_len(st_d, cur_t_q);
						capture = (st_q == ST_E) & rw_q;
						cyc_end = (st_d == ST_IDLE);
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
				cnt_d = 6'h00;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			cnt_q <= 6'h00;
			cur_t_q <= `EBPS_TIMING_RST;
			last_win_q <= {`EBPS_WIN_W{1'b0}};
			win_valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			if (start) begin
				// Snapshot so mid-cycle timing writes cannot bend a running cycle
				cur_t_q <= timing_q;
				last_win_q <= new_win;
				win_valid_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Bus pins
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_addr <= {ADDR_W{1'b0}};
			bus_wdata <= {DATA_W{1'b0}};
			bus_data_oe_n <= 1'b1;
			bus_cs_n <= 1'b1;
			bus_rd_n <= 1'b1;
			bus_wr_n <= 1'b1;
			rdata_q <= {DATA_W{1'b0}};
		end else begin
			// Address stays put after the cycle, covering the hold phase
			if (start) begin
				bus_addr <= addr_q;
				bus_wdata <= wdata_q;
			end
			bus_cs_n <= (st_d == ST_IDLE);
			bus_rd_n <= ~(rw_q & (st_d == ST_E));
			bus_wr_n <= ~(~rw_q & (st_d == ST_E));
			bus_data_oe_n <= ~(~rw_q & ((st_d == ST_D) | (st_d == ST_E) | (st_d == ST_F)));
			if (capture)
				rdata_q <= rdata_s;
		end
	end

	// Reference clock is the system clock itself, not a divided copy
	assign external_clock_output_pin = pclk;

	// ****************************************************************
	// APB register file
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `EBPS_CTRL_RST;
			timing_q <= `EBPS_TIMING_RST;
			div_q <= `EBPS_DIV_RST;
			rw_q <= 1'b0;
			addr_q <= {ADDR_W{1'b0}};
			wdata_q <= {DATA_W{1'b0}};
			done_q <= 1'b0;
			ext_clk_hs_drv_en <= 1'b0;
		end else begin
			ext_clk_hs_drv_en <= ctrl_q[`EBPS_CTRL_REFERENCE_BUS_CLOCK_OUTPUT_EN];
			if (apb_wr) begin
				case (paddr)
					`EBPS_OFS_CTRL: ctrl_q <= pwdata[`EBPS_CTRL_W-1:0];
					`EBPS_OFS_TIMING: timing_q <= pwdata[`EBPS_T_W-1:0];
					`EBPS_OFS_DIV: div_q <= pwdata[7:0];
					`EBPS_OFS_CMD: if (!busy) rw_q <= pwdata[0];
					`EBPS_OFS_ADDR: if (!busy) addr_q <= pwdata[ADDR_W-1:0];
					`EBPS_OFS_WDATA: if (!busy) wdata_q <= pwdata[DATA_W-1:0];
					default: ;
				endcase
			end
			// Completion beats a simultaneous clear
			if (cyc_end)
				done_q <= 1'b1;
			else if (done_clr)
				done_q <= 1'b0;
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		case (paddr)
			`EBPS_OFS_CTRL: rd_mux[`EBPS_CTRL_W-1:0] = ctrl_q;
			`EBPS_OFS_TIMING: rd_mux[`EBPS_T_W-1:0] = timing_q;
			`EBPS_OFS_DIV: rd_mux[7:0] = div_q;
			`EBPS_OFS_CMD: rd_mux[0] = rw_q;
			`EBPS_OFS_ADDR: rd_mux[ADDR_W-1:0] = addr_q;
			`EBPS_OFS_WDATA: rd_mux[DATA_W-1:0] = wdata_q;
			`EBPS_OFS_RDATA: rd_mux[DATA_W-1:0] = rdata_q;
			`EBPS_OFS_STATUS: begin
				rd_mux[`EBPS_ST_BUSY] = busy;
				rd_mux[`EBPS_ST_DONE] = done_q;
				rd_mux[`EBPS_ST_PH_LSB +: 6] = st_q;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data registered in the setup cycle, stable through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (apb_setup & ~pwrite)
			prdata <= rd_mux;
	end

endmodule // ebps_top

`default_nettype wire

// ==== verif/ebps_bus_monitor.sv ====
// Purpose: Port checks for the bus phase sequencer.
// Assumes: A step is never shorter than four pclk cycles.
// Notes:   Bound into every ebps_top.
`timescale 1ns/1ps
`default_nettype none
module ebps_bus_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bus_cs_n,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic bus_data_oe_n,
	input wire logic ext_clk_hs_drv_en
);
	// ******
	// Checks
	// ******
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd_fall;
		$fell(bus_rd_n) || $fell(bus_wr_n);
	endsequence
	sequence s_cmd_step;
		(!bus_rd_n || !bus_wr_n) [*4];
	endsequence
	// One full step of strobe keeps bus edges 12.5 ns apart
	cmd_step_a: assert property (s_cmd_fall |-> s_cmd_step)
		else $error("strobe shorter than a step");
	setup_step_a: assert property ($fell(bus_cs_n) |-> (bus_rd_n && bus_wr_n) [*4])
		else $error("no address setup step");
	cmd_in_cs_a: assert property (!bus_rd_n || !bus_wr_n |-> !bus_cs_n)
		else $error("strobe outside select");
	one_cmd_a: assert property (!bus_rd_n |-> bus_wr_n)
		else $error("both strobes low");
	wdata_drive_a: assert property (!bus_data_oe_n |-> !bus_cs_n && bus_rd_n)
		else $error("data driven outside write");
	hold_drive_a: assert property ($rose(bus_wr_n) && !bus_cs_n |-> !bus_data_oe_n)
		else $error("write data dropped in hold");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access not ready");
	unmapped_err_a: assert property (psel && penable && paddr >= 8'h20 |-> pslverr)
		else $error("unmapped access without error");
	clk_drive_a: assert property (psel && penable && pwrite && paddr == 8'h00
		|-> ##2 ext_clk_hs_drv_en == $past(pwdata[3], 2))
		else $error("clock driver enable wrong");
endmodule // ebps_bus_monitor
bind ebps_top ebps_bus_monitor ebps_bus_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_data_oe_n,
	.ext_clk_hs_drv_en);
`default_nettype wire

// ==== verif/ebps_mem_model.sv ====
// Purpose: External memory on the parallel bus, with a slow ready.
// Assumes: Ready active high; sixteen words decoded from address bits 3:0.
// Notes:   Released data lines show the inverse of the last driven word.
`timescale 1ns/1ps
`default_nettype none
module ebps_mem_model (
	input wire logic clk,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic [23:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [3:0] dly,
	output logic [15:0] rdata,
	output logic ready
);
	logic [15:0] mem [0:15];
	logic [15:0] last = 16'h0000;
	int cnt = 0;
	always @(posedge clk) begin
		if (!cs_n && !wr_n && !oe_n) mem[addr[3:0]] <= wdata;
		if (!cs_n && !rd_n) last <= mem[addr[3:0]];
		cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
	end
	// Ready comes only after dly strobe cycles, forcing waitstates
	always @* rdata = (!cs_n && !rd_n) ? mem[addr[3:0]] : ~last;
	always @* ready = !(rd_n && wr_n) && cnt >= dly;
endmodule // ebps_mem_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the bus phase sequencer.
// Assumes: Step of four pclk cycles unless the divider asks for more.
// Notes:   Bus cycles are measured by counting low select and strobe cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ebps_defines.vh"
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, err, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe_n, bus_ready_in;
	logic external_clock_output_pin, ext_clk_hs_drv_en;
	logic [23:0] bus_addr;
	logic [15:0] bus_wdata, bus_rdata_in;
	// Synchronous ready then lands on a step edge, so the extra async stage costs a step
	logic [3:0] dly = 4'h9;
	int fails = 0, total_checks = 0, cs_cnt, st_cnt, n, sync_len, stp = 4;
	always #2 pclk = ~pclk;
	ebps_top ebps_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .bus_addr, .bus_wdata, .bus_data_oe_n, .bus_rdata_in, .bus_cs_n,
		.bus_rd_n, .bus_wr_n, .bus_ready_in, .external_clock_output_pin, .ext_clk_hs_drv_en);
	ebps_mem_model ebps_mem_model_i (.clk(external_clock_output_pin), .cs_n(bus_cs_n),
		.rd_n(bus_rd_n), .wr_n(bus_wr_n), .oe_n(bus_data_oe_n), .addr(bus_addr),
		.wdata(bus_wdata), .dly(dly), .rdata(bus_rdata_in), .ready(bus_ready_in));
	always @(posedge pclk) begin
		if (bus_cs_n === 1'b0) cs_cnt++;
		if (bus_rd_n === 1'b0 || bus_wr_n === 1'b0) st_cnt++;
	end
	// ******
	// Tasks
	// ******
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic bus_op(input logic [23:0] a, input logic [15:0] d, input logic rd,
		input int steps, input int e);
		apb(1'b1, `EBPS_OFS_ADDR, {8'h00, a});
		apb(1'b1, `EBPS_OFS_WDATA, {16'h0000, d});
		cs_cnt = 0;
		st_cnt = 0;
		apb(1'b1, `EBPS_OFS_CMD, {31'h0, rd});
		r = 32'h0;
		for (n = 0; n < 200 && r[1] !== 1'b1; n++) apb(1'b0, `EBPS_OFS_STATUS, 32'h0);
		chk(r, 32'h6);
		apb(1'b1, `EBPS_OFS_STATUS, 32'h2);
		apb(1'b0, `EBPS_OFS_STATUS, 32'h0);
		chk(r, 32'h4);
		// The divider restarts on the command, so the first step runs one clock longer
		if (steps > 0) chk(cs_cnt, steps * stp + 1);
		if (e > 0) chk(st_cnt, e * stp);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 12; n += 4) begin
			apb(1'b0, n[7:0], 32'h0);
			chk(r, 32'h0);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset_map done");
		apb(1'b1, `EBPS_OFS_DIV, 32'h1);
		bus_op(24'h000003, 16'h1234, 1'b0, 2, 1);
		chk({8'h0, bus_addr}, 32'h3);
		apb(1'b1, `EBPS_OFS_TIMING, 32'h1fff);
		bus_op(24'h100005, 16'ha5c3, 1'b0, 44, 32);
		apb(1'b1, `EBPS_OFS_TIMING, 32'h7);
		bus_op(24'h100005, 16'h0, 1'b1, 3, 1);
		apb(1'b0, `EBPS_OFS_RDATA, 32'h0);
		chk(r, 32'ha5c3);
		bus_op(24'h000003, 16'h0, 1'b1, 6, 1);
		apb(1'b0, `EBPS_OFS_RDATA, 32'h0);
		chk(r, 32'h1234);
		apb(1'b1, `EBPS_OFS_TIMING, 32'h0);
		apb(1'b1, `EBPS_OFS_DIV, 32'h7);
		stp = 8;
		bus_op(24'h000004, 16'h0, 1'b0, 2, 1);
		stp = 4;
		apb(1'b1, `EBPS_OFS_DIV, 32'h0);
		$display("test phases done");
		apb(1'b1, `EBPS_OFS_CTRL, 32'h3);
		bus_op(24'h000004, 16'h0, 1'b0, 0, 0);
		chk({31'h0, st_cnt >= 12 && st_cnt % 4 == 0}, 32'h1);
		sync_len = st_cnt;
		apb(1'b1, `EBPS_OFS_CTRL, 32'h7);
		bus_op(24'h000004, 16'h0, 1'b0, 0, 0);
		chk({31'h0, st_cnt > sync_len}, 32'h1);
		apb(1'b1, `EBPS_OFS_CTRL, 32'h1);
		bus_op(24'h000004, 16'h0, 1'b0, 2, 1);
		apb(1'b1, `EBPS_OFS_CTRL, 32'h8);
		repeat (2) @(posedge pclk);
		chk({31'h0, ext_clk_hs_drv_en}, 32'h1);
		// Reference clock pin must follow the system clock in both halves
		@(negedge pclk);
		#1;
		chk({31'h0, external_clock_output_pin}, 32'h0);
		@(posedge pclk);
		#1;
		chk({31'h0, external_clock_output_pin}, 32'h1);
		$display("test ready done");
		print_verdict;
	end
endmodule // tb
`default_nettype wire
